// File: bench/nie_chk.sv
// Purpose: Port checker for request and error block
// Assumes: Pin output settles within 3 cycles of an enable write
// Notes: Enable values are shadowed from completed APB writes
`timescale 1ns/100ps
module nie_chk (
   input wire ref_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire buf_write,
   input wire buf_full,
   input wire frame_end,
   input wire [3:0] frame_bits,
   input wire [7:0] frame_bytes,
   input wire framing_error,
   input wire buf_write_accept,
   input wire frame_discard,
   input wire rx_stop,
   input wire drop_last_byte,
   input wire decoder_keep,
   input wire irq_pin_o,
   input wire irq_pin_oe
);
   reg [7:0] en0_reg; // Shadow of enable group 0
   reg [7:0] en1_reg; // Shadow of enable group 1
   reg [1:0] age_reg; // Cycles since enable write, saturating
   wire wr_ok = psel && penable && pready && pwrite;
   wire calm = age_reg == 2'h3;
   // Shadow copy; pin checks wait until the pipe has settled
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         en0_reg <= 8'h00;
         en1_reg <= 8'h00;
         age_reg <= 2'h0;
      end else begin
         if (wr_ok && paddr == 12'h020) en0_reg <= pwdata[7:0];
         if (wr_ok && paddr == 12'h024) en1_reg <= pwdata[7:0];
         if (wr_ok && paddr[11:3] == 9'h004) age_reg <= 2'h0;
         else if (!calm) age_reg <= age_reg + 2'h1;
      end
   end
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   AST_RDY: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_SLV: assert property (pready && !(paddr inside {12'h018, 12'h01C,
      12'h020, 12'h024, 12'h028, 12'h080, 12'h084}) |-> pslverr)
      else $error("unmapped access not refused");
   AST_PP: assert property (calm && en1_reg[7] |-> irq_pin_oe)
      else $error("push-pull pin not driven");
   AST_OD: assert property (calm && !en1_reg[7] && irq_pin_oe |->
      !irq_pin_o)
      else $error("open-drain pin driven high");
   AST_GATE: assert property (calm && !en1_reg[6] |->
      (en1_reg[7] ? irq_pin_o : irq_pin_oe) == en0_reg[7])
      else $error("gated pin not idle at chosen polarity");
   AST_OVF: assert property (buf_write && buf_full |=> !buf_write_accept)
      else $error("write to full buffer accepted");
   AST_SHORT: assert property (frame_end && frame_bytes == 8'h00 &&
      frame_bits < 4'h4 |=> frame_discard && decoder_keep)
      else $error("short frame kept");
   AST_PROT: assert property (framing_error |=> rx_stop)
      else $error("reception not stopped");
   AST_DROP: assert property (framing_error |=> ##0 drop_last_byte)
      else $error("last byte not dropped");
   cover property (calm && en1_reg[7] && irq_pin_o);
   cover property (frame_discard);
   cover property (pready && pslverr);
endmodule // nie_chk

// File: bench/nie_host_mdl.sv
// Purpose: Host side of the interrupt pin
// Assumes: Board pull-up on the pin
// Notes: Released pin reads high, never a stale level
`timescale 1ns/100ps
module nie_host_mdl (
   input wire irq_pin_o,
   input wire irq_pin_oe,
   output wire pin_level
);
   // Wire level seen by the host; pull-up wins when released
   assign pin_level = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule // nie_host_mdl

// File: bench/tb_nfc_irq_enable_and_error_flags.sv
// Purpose: Self-checking bench for request and error block
// Assumes: APB slave answers within a bounded number of cycles
// Notes: Pulses and levels are packed into two driver vectors
`timescale 1ns/100ps
`include "nie_defs.vh"
module tb_nfc_irq_enable_and_error_flags;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [22:0] ev = 23'h000000; // One-cycle event pulses
   logic [7:0] lv = 8'h00; // Level inputs
   logic [3:0] frame_bits = 4'h0;
   logic [7:0] frame_bytes = 8'h00;
   logic [7:0] collision_pos = 8'h00;
   logic [31:0] rd; // Last read data
   logic sl; // Last error response
   logic acc; // Buffer write accept seen
   int n_mismatch = 0;
   int samples_checked = 0;
   wire [31:0] prdata;
   wire pready, pslverr, buf_write_accept, frame_discard, rx_stop;
   wire drop_last_byte, decoder_keep, irq_pin_o, irq_pin_oe, pin_level;
   // Unpack pulses: index is the kick argument
   wire nvm_cmd_done = ev[0], buf_write = ev[1], cmd_start = ev[2];
   wire rx_cmd_start = ev[3], enter_wait_data = ev[4];
   wire errors_stored = ev[5], frame_end = ev[6], send_request = ev[7];
   wire collision = ev[8], framing_error = ev[9];
   wire integrity_error = ev[10];
   wire [5:0] req0_events = ev[16:11], req1_events = ev[22:17];
   // Unpack levels
   wire nvm_cmd_error = lv[0], buf_full = lv[1], busy_crc_send = lv[2];
   wire busy_receive_state = lv[3], busy_auth = lv[4], buf_empty = lv[5];
   wire collision_in_eof = lv[6], card_detect_async = lv[7];
   nie_irq_err uut (.*);
   nie_host_mdl host (.*);
   // 25 MHz clock
   initial forever #20 ref_clk = ~ref_clk;
   // Masked compare of any result
   task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
      samples_checked++;
      if ((g & m) !== (e & m)) begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   // One APB transfer; request held until ready is sampled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      sl = pslverr;
      chk({31'h0, pready}, 32'h1, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask
   // Pulse one or two events; accept is captured afterwards
   task kick(input int i, input int j);
      ev <= (23'h000001 << i) | (23'h000001 << j);
      @(posedge ref_clk);
      ev <= 23'h000000;
      @(posedge ref_clk);
      acc = buf_write_accept;
   endtask
   task idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task pin(input logic e);
      chk({31'h0, pin_level}, {31'h0, e}, 32'h1);
   endtask
   task t_reset;
      rchk(`NIE_ADDR_EN0, 32'h0, 32'hFFFFFFFF);
      rchk(`NIE_ADDR_ERR, 32'h0, 32'hFF);
      apb(1'b0, 12'hFFC, 32'h0);
      chk({31'h0, sl}, 32'h1, 32'h1);
   endtask
   // First position kept, end-symbol collision ignored
   task t_coll;
      collision_pos <= 8'h05;
      kick(8, 8);
      collision_pos <= 8'h09;
      kick(8, 8);
      rchk(`NIE_ADDR_COLL, 32'h105, 32'h1FF);
      rchk(`NIE_ADDR_ERR, 32'h04, 32'h05);
      kick(3, 3);
      apb(1'b1, `NIE_ADDR_CTRL, 32'h1);
      lv <= 8'h40;
      kick(8, 8);
      rchk(`NIE_ADDR_ERR, 32'h0, 32'h04);
      lv <= 8'h00;
      kick(8, 8);
      rchk(`NIE_ADDR_ERR, 32'h05, 32'h05);
      apb(1'b1, `NIE_ADDR_CTRL, 32'h0);
   endtask
   // Error flags set, fault request, then auto clears
   task t_err;
      kick(3, 3);
      kick(1, 1);
      chk({31'h0, acc}, 32'h1, 32'h1);
      lv <= 8'h01;
      kick(0, 0);
      lv <= 8'h20;
      kick(7, 7);
      lv <= 8'h02;
      kick(1, 1);
      lv <= 8'h00;
      kick(1, 1);
      chk({31'h0, acc}, 32'h0, 32'h1);
      kick(9, 9);
      kick(10, 10);
      rchk(`NIE_ADDR_ERR, 32'hAB, 32'hFF);
      rchk(`NIE_ADDR_REQ0, 32'h02, 32'h02);
      kick(4, 4);
      rchk(`NIE_ADDR_ERR, 32'h80, 32'h97);
      kick(0, 0);
      rchk(`NIE_ADDR_ERR, 32'h0, 32'h80);
   endtask
   // Buffer writes in each busy state, cleared by command start
   task t_wr;
      for (int i = 2; i < 5; i++) begin
         lv <= 8'h01 << i;
         kick(1, 1);
         lv <= 8'h00;
         rchk(`NIE_ADDR_ERR, 32'h40, 32'h40);
         kick(2, 2);
         rchk(`NIE_ADDR_ERR, 32'h0, 32'h40);
      end
      // Multi-frame receive: only the stored error word clears it
      apb(1'b1, `NIE_ADDR_CTRL, 32'h2);
      lv <= 8'h04;
      kick(1, 1);
      lv <= 8'h00;
      kick(2, 2);
      rchk(`NIE_ADDR_ERR, 32'h40, 32'h40);
      kick(5, 5);
      rchk(`NIE_ADDR_ERR, 32'h0, 32'h40);
      apb(1'b1, `NIE_ADDR_CTRL, 32'h0);
   endtask
   // Short frames discarded without receive done
   task t_short;
      frame_bits <= 4'h3;
      kick(6, 12);
      rchk(`NIE_ADDR_ERR, 32'h10, 32'h10);
      rchk(`NIE_ADDR_REQ0, 32'h0, 32'h04);
      frame_bits <= 4'h4;
      kick(6, 12);
      rchk(`NIE_ADDR_REQ0, 32'h04, 32'h04);
      apb(1'b1, `NIE_ADDR_CTRL, 32'h4);
      apb(1'b1, `NIE_ADDR_REQ0, 32'h7F);
      frame_bits <= 4'h0;
      frame_bytes <= 8'h02;
      kick(6, 12);
      rchk(`NIE_ADDR_REQ0, 32'h0, 32'h04);
      frame_bytes <= 8'h03;
      kick(6, 12);
      rchk(`NIE_ADDR_REQ0, 32'h04, 32'h04);
      apb(1'b1, `NIE_ADDR_CTRL, 32'h0);
   endtask
   // Masks, global flag, polarity, gate and drive style
   task t_pin;
      apb(1'b1, `NIE_ADDR_REQ0, 32'h7F);
      apb(1'b1, `NIE_ADDR_REQ1, 32'h7F);
      apb(1'b1, `NIE_ADDR_EN0, 32'h04);
      apb(1'b1, `NIE_ADDR_EN1, 32'hC0);
      idle(3);
      pin(1'b0);
      kick(12, 12);
      idle(3);
      pin(1'b1);
      rchk(`NIE_ADDR_REQ1, 32'h40, 32'h40);
      apb(1'b1, `NIE_ADDR_EN0, 32'h84);
      idle(3);
      pin(1'b0);
      apb(1'b1, `NIE_ADDR_EN1, 32'h80);
      idle(3);
      pin(1'b1);
      apb(1'b1, `NIE_ADDR_EN1, 32'h40);
      idle(3);
      pin(1'b1);
      apb(1'b1, `NIE_ADDR_EN0, 32'h04);
      idle(3);
      pin(1'b0);
      apb(1'b1, `NIE_ADDR_REQ0, 32'h7F);
      apb(1'b1, `NIE_ADDR_REQ1, 32'h7F);
      apb(1'b1, `NIE_ADDR_EN1, 32'hC1);
      kick(17, 17);
      idle(3);
      pin(1'b1);
      lv <= 8'h80;
      idle(5);
      rchk(`NIE_ADDR_REQ1, 32'h20, 32'h20);
      lv <= 8'h00;
      apb(1'b1, `NIE_ADDR_REQ0, 32'hFF);
      rchk(`NIE_ADDR_REQ0, 32'h7F, 32'h7F);
   endtask
   task results;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Main sequence after a 3-cycle reset
   initial begin
      idle(3);
      rst_n <= 1'b1;
      idle(1);
      t_reset;
      t_coll;
      t_err;
      t_wr;
      t_short;
      t_pin;
      results;
   end
   // Hang guard, far beyond the expected run
   initial begin
      idle(20000);
      n_mismatch++;
      results;
   end
endmodule // tb_nfc_irq_enable_and_error_flags
bind nie_irq_err nie_chk chk_i (.*);

// File: rtl/nie_defs.vh
// Purpose: Constants for the request enable and error flag block
// Assumes: APB byte addresses equal register index times four
// Notes: Printed offsets are indices, not all multiples of four
`ifndef NIE_DEFS_VH
`define NIE_DEFS_VH
// Register indices as printed
`define NIE_IDX_REQ0 8'h06
`define NIE_IDX_REQ1 8'h07
`define NIE_IDX_EN0 8'h08
`define NIE_IDX_EN1 8'h09
`define NIE_IDX_ERR 8'h0A
`define NIE_IDX_CTRL 8'h20
`define NIE_IDX_COLL 8'h21
// Byte addresses derived from indices
`define NIE_ADDR_REQ0 12'h018
`define NIE_ADDR_REQ1 12'h01C
`define NIE_ADDR_EN0 12'h020
`define NIE_ADDR_EN1 12'h024
`define NIE_ADDR_ERR 12'h028
`define NIE_ADDR_CTRL 12'h080
`define NIE_ADDR_COLL 12'h084
// Field positions
`define NIE_EN0_INVERT 7
`define NIE_EN1_PUSHPULL 7
`define NIE_EN1_PINGATE 6
`define NIE_REQ_SET 7
`define NIE_REQ0_FAULT 1
`define NIE_REQ0_RXDONE 2
`define NIE_REQ1_GLOBAL 6
`define NIE_ERR_NVM 7
`define NIE_ERR_WRFAULT 6
`define NIE_ERR_OVF 5
`define NIE_ERR_SHORT 4
`define NIE_ERR_NODATA 3
`define NIE_ERR_COLL 2
`define NIE_ERR_PROT 1
`define NIE_ERR_INTEG 0
`define NIE_CTRL_COLLERR 0
`define NIE_CTRL_MULTI 1
`define NIE_CTRL_EMD 2
// Reset values
`define NIE_RST_BYTE 8'h00
// Frame length minima
`define NIE_MIN_BITS 4
`define NIE_MIN_BYTES_EMD 3
`endif

// File: rtl/nie_irq_err.v
// Purpose: Request enables, combined request, pin and error flags
// Assumes: Event inputs are one-cycle pulses on ref_clk
// Notes on behaviour
// - Polarity bit inverts interrupt pin
// - Group zero enables gate flags to combined
// - Group one enables gate detect, timer flags
// - Style bit selects push-pull, else open-drain
// - Pin gate bit passes combined request
// - Memory command error sets top flag
// - Bad-time buffer writes set write fault
// - Write fault clears on command start, or on error store in multi-frame
// - Full-buffer write sets overflow, blocks writes
// - Under four bits: short fault, discard
// - Suppression mode: under three bytes discarded
// - Receive start clears frame error flags
// - Send with empty buffer sets fault
// - Collision sets flag, records first position
// - End symbol collision is ignored
// - Framing errors set flag, stop reception
// - Framing error drops last byte
// - Parity or CRC mismatch sets integrity
// - Collision-as-error also sets integrity
// - Error flags except memory, short and collision raise fault request flag
// - Enabled request raises combined flag
// - Request writes set or clear marked bits
`timescale 1ns/100ps
`include "nie_defs.vh"
module nie_irq_err #(
   parameter COLL_W = 8
) (
   input wire ref_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [5:0] req0_events,
   input wire [5:0] req1_events,
   input wire nvm_cmd_done,
   input wire nvm_cmd_error,
   input wire buf_write,
   input wire buf_full,
   input wire busy_crc_send,
   input wire busy_receive_state,
   input wire busy_auth,
   input wire cmd_start,
   input wire rx_cmd_start,
   input wire enter_wait_data,
   input wire errors_stored,
   input wire frame_end,
   input wire [3:0] frame_bits,
   input wire [7:0] frame_bytes,
   input wire send_request,
   input wire buf_empty,
   input wire collision,
   input wire collision_in_eof,
   input wire [COLL_W-1:0] collision_pos,
   input wire framing_error,
   input wire integrity_error,
   input wire card_detect_async,
   output reg buf_write_accept,
   output reg frame_discard,
   output reg rx_stop,
   output reg drop_last_byte,
   output reg decoder_keep,
   output wire irq_pin_o,
   output wire irq_pin_oe
);
   // Register map, byte address is the index times four:
   //  0x018 group zero request flags, bit 7 picks set or clear
   //  0x01C group one request flags, bit 6 is the combined flag
   //  0x020 group zero enables, bit 7 inverts the pin
   //  0x024 group one enables, bit 7 push-pull, bit 6 pin gate
   //  0x028 error flags, hardware owned, not writable
   //  0x080 control: collision-as-error, multi-frame, suppression
   //  0x084 first collision position, valid flag above it
   // Unmapped addresses answer with an error and read as zero
   // Every register is nine bits or less; upper data bits read 0
   reg [7:0] en0_reg; // Group zero enables and polarity
   reg [7:0] en1_reg; // Group one enables and pin controls
   reg [6:0] req0_reg; // Group zero request flags
   reg [6:0] req1_reg; // Group one request flags, bit 6 combined
   reg [7:0] err_reg; // Error flags
   reg [2:0] ctrl_reg; // Collision-as-error, multi-frame, suppression
   reg [COLL_W-1:0] coll_pos_reg; // First collision position
   reg coll_valid_reg; // Position holds a collision
   reg pin_req_reg; // Gated request toward pin
   reg [7:0] err_next;
   reg [6:0] req0_next;
   reg [6:0] req1_next;
   reg [31:0] rd_next;
   reg wr_req0;
   reg wr_req1;
   reg short_frame;
   reg err_set_any;
   reg [6:0] wmask;
   reg wset;
   wire card_detect; // Synchronised detect level
   reg card_detect_d; // Previous detect level for edge
   wire apb_wr; // Write takes effect this edge
   wire apb_rd; // Read data taken this edge

   // Writes land in the access phase, where the request is final.
   // Read data is captured at the setup edge so that it stands,
   // registered, through the single access cycle.
   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & ~penable & ~pwrite;

   // Map an APB byte address to a known register
   // Only exact word addresses match; anything else is refused
   function addr_known;
      input [11:0] a;
      begin
         addr_known = (a == `NIE_ADDR_REQ0) || (a == `NIE_ADDR_REQ1) ||
            (a == `NIE_ADDR_EN0) || (a == `NIE_ADDR_EN1) ||
            (a == `NIE_ADDR_ERR) || (a == `NIE_ADDR_CTRL) ||
            (a == `NIE_ADDR_COLL);
      end
   endfunction

   // Card detect comes from an analogue domain
   // Two stages keep a metastable level away from the edge detect
   nie_sync2 u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .din(card_detect_async),
      .dout(card_detect)
   );

   // Error flag next state; sets are applied after clears so sets win
   always @* begin
      err_next = err_reg;
      short_frame = 1'b0;
      wr_req0 = apb_wr && (paddr == `NIE_ADDR_REQ0);
      wr_req1 = apb_wr && (paddr == `NIE_ADDR_REQ1);
      wset = pwdata[`NIE_REQ_SET];
      wmask = pwdata[6:0];
      // Clears first
      // In multi-frame receive the write fault must survive until the
      // error word has been stored, so command start is ignored then
      if (ctrl_reg[`NIE_CTRL_MULTI]) begin
         if (errors_stored)
            err_next[`NIE_ERR_WRFAULT] = 1'b0;
      end else if (cmd_start) begin
         err_next[`NIE_ERR_WRFAULT] = 1'b0;
      end
      // Receive and transceive starts share one clear; transceive
      // arrives here as the entry to the wait-for-data state
      if (rx_cmd_start || enter_wait_data) begin
         err_next[`NIE_ERR_SHORT] = 1'b0;
         err_next[`NIE_ERR_COLL] = 1'b0;
         err_next[`NIE_ERR_PROT] = 1'b0;
         err_next[`NIE_ERR_INTEG] = 1'b0;
      end
      // Top flag reflects only the most recent memory command
      if (nvm_cmd_done)
         err_next[`NIE_ERR_NVM] = nvm_cmd_error;
      // Sets come last, so a set and a clear in one cycle leave it set
      if (buf_write && (busy_crc_send || busy_receive_state || busy_auth))
         err_next[`NIE_ERR_WRFAULT] = 1'b1;
      if (buf_write && buf_full)
         err_next[`NIE_ERR_OVF] = 1'b1;
      // Whole bytes and trailing bits together give the length
      if (frame_end && frame_bytes == 8'h00 &&
          frame_bits < `NIE_MIN_BITS) begin
         err_next[`NIE_ERR_SHORT] = 1'b1;
         short_frame = 1'b1;
      end
      // Suppression discards silently; no flag is defined for it
      if (frame_end && ctrl_reg[`NIE_CTRL_EMD] &&
          frame_bytes < `NIE_MIN_BYTES_EMD)
         short_frame = 1'b1;
      if (send_request && buf_empty)
         err_next[`NIE_ERR_NODATA] = 1'b1;
      // A collision inside the end symbol is legal signalling
      if (collision && !collision_in_eof) begin
         err_next[`NIE_ERR_COLL] = 1'b1;
         if (ctrl_reg[`NIE_CTRL_COLLERR])
            err_next[`NIE_ERR_INTEG] = 1'b1;
      end
      if (framing_error)
         err_next[`NIE_ERR_PROT] = 1'b1;
      // Integrity faults never stop reception
      if (integrity_error)
         err_next[`NIE_ERR_INTEG] = 1'b1;
      // Fault request on rising edge of any listed error
      // Short-frame and collision flags are not listed, so they
      // never raise the fault request on their own
      err_set_any = (err_next[`NIE_ERR_WRFAULT] &
                     ~err_reg[`NIE_ERR_WRFAULT]) |
                    (err_next[`NIE_ERR_OVF] & ~err_reg[`NIE_ERR_OVF]) |
                    (err_next[`NIE_ERR_PROT] & ~err_reg[`NIE_ERR_PROT]) |
                    (err_next[`NIE_ERR_NODATA] &
                     ~err_reg[`NIE_ERR_NODATA]) |
                    (err_next[`NIE_ERR_INTEG] & ~err_reg[`NIE_ERR_INTEG]);
   end

   // Request flag next state: software write, then hardware sets win
   always @* begin
      req0_next = req0_reg;
      req1_next = req1_reg;
      if (wr_req0)
         req0_next = wset ? (req0_reg | wmask) : (req0_reg & ~wmask);
      if (wr_req1)
         req1_next = wset ? (req1_reg | wmask) : (req1_reg & ~wmask);
      // Group zero sources: high, low, idle, tx, rx at 6..2, sof at 0
      req0_next[6:2] = req0_next[6:2] | req0_events[5:1];
      req0_next[0] = req0_next[0] | req0_events[0];
      // A discarded frame never raises receive done
      // A clear write still acts; only the raise is held back
      if (short_frame)
         req0_next[`NIE_REQ0_RXDONE] = req0_reg[`NIE_REQ0_RXDONE] &
            ~(wr_req0 & ~wset & wmask[`NIE_REQ0_RXDONE]);
      // Fault request follows a new listed error at the same edge
      if (err_set_any)
         req0_next[`NIE_REQ0_FAULT] = 1'b1;
      req1_next[4:0] = req1_next[4:0] | req1_events[4:0];
      // Card detect arrives as a level; only its rising edge counts
      req1_next[5] = req1_next[5] | req1_events[5] |
         (card_detect & ~card_detect_d);
      // Combined flag is sticky: software clears it, and hardware
      // sets it again while any enabled flag stays set
      if (|(req0_next & en0_reg[6:0]) | |(req1_next[5:0] & en1_reg[5:0]))
         req1_next[`NIE_REQ1_GLOBAL] = 1'b1;
   end

   // Register read mux
   // Flags read as stored; reading never clears anything
   always @* begin
      rd_next = 32'h00000000;
      case (paddr)
         `NIE_ADDR_REQ0: rd_next[6:0] = req0_reg;
         `NIE_ADDR_REQ1: rd_next[6:0] = req1_reg;
         `NIE_ADDR_EN0: rd_next[7:0] = en0_reg;
         `NIE_ADDR_EN1: rd_next[7:0] = en1_reg;
         `NIE_ADDR_ERR: rd_next[7:0] = err_reg;
         `NIE_ADDR_CTRL: rd_next[2:0] = ctrl_reg;
         `NIE_ADDR_COLL: rd_next[COLL_W:0] = {coll_valid_reg, coll_pos_reg};
         default: rd_next = 32'h00000000;
      endcase
   end

   // APB slave: no wait state, ready in the access phase
   // Limitation: ready is a one-cycle pulse after every setup cycle,
   // so each transfer takes exactly two cycles, mapped or not
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_known(paddr);
         if (apb_rd)
            prdata <= rd_next;
      end
   end

   // Enables, control and flags
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         en0_reg <= `NIE_RST_BYTE;
         en1_reg <= `NIE_RST_BYTE;
         err_reg <= `NIE_RST_BYTE;
         req0_reg <= 7'h00;
         req1_reg <= 7'h00;
         ctrl_reg <= 3'h0;
         card_detect_d <= 1'b0;
      end else begin
         // Error register is hardware owned; writes to it are dropped
         if (apb_wr && paddr == `NIE_ADDR_EN0)
            en0_reg <= pwdata[7:0];
         if (apb_wr && paddr == `NIE_ADDR_EN1)
            en1_reg <= pwdata[7:0];
         if (apb_wr && paddr == `NIE_ADDR_CTRL)
            ctrl_reg <= pwdata[2:0];
         // Error and request flags take their next state every cycle
         err_reg <= err_next;
         req0_reg <= req0_next;
         req1_reg <= req1_next;
         card_detect_d <= card_detect;
      end
   end

   // First collision position, cleared with the collision flag
   // A clear and a new collision in one cycle keep the new position
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         coll_pos_reg <= {COLL_W{1'b0}};
         coll_valid_reg <= 1'b0;
      end else if (collision && !collision_in_eof &&
                   (!coll_valid_reg || rx_cmd_start || enter_wait_data)) begin
         coll_pos_reg <= collision_pos;
         coll_valid_reg <= 1'b1;
      end else if (rx_cmd_start || enter_wait_data) begin
         coll_valid_reg <= 1'b0;
      end
   end

   // Datapath strobes, registered so outputs come from flip-flops
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_write_accept <= 1'b0;
         frame_discard <= 1'b0;
         rx_stop <= 1'b0;
         drop_last_byte <= 1'b0;
         decoder_keep <= 1'b0;
         pin_req_reg <= 1'b0;
      end else begin
         // Once overflowed, every later write is ignored
         // Limitation: overflow has no clear here, so writes stay
         // blocked until reset
         buf_write_accept <= buf_write & ~buf_full &
            ~err_reg[`NIE_ERR_OVF];
         // Discard and decoder keep mark the same event
         frame_discard <= short_frame;
         decoder_keep <= short_frame;
         rx_stop <= framing_error;
         drop_last_byte <= framing_error;
         // Pin path is registered twice after the combined flag
         pin_req_reg <= req1_reg[`NIE_REQ1_GLOBAL] &
            en1_reg[`NIE_EN1_PINGATE];
      end
   end

   // Pin drive stage
   // Polarity and style act after the gate, so a gated pin rests
   // at the deasserted level of the chosen polarity
   nie_pin_drive u_pin (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .request(pin_req_reg),
      .invert(en0_reg[`NIE_EN0_INVERT]),
      .push_pull(en1_reg[`NIE_EN1_PUSHPULL]),
      .irq_pin_o(irq_pin_o),
      .irq_pin_oe(irq_pin_oe)
   );
endmodule // nie_irq_err

// File: rtl/nie_pin_drive.v
// Purpose: Interrupt pin polarity and drive style
// Assumes: Request and config come from flip-flops on ref_clk
// Notes: Outputs registered; open-drain drives only while level is high
`timescale 1ns/100ps
module nie_pin_drive (
   input wire ref_clk,
   input wire rst_n,
   input wire request,
   input wire invert,
   input wire push_pull,
   output reg irq_pin_o,
   output reg irq_pin_oe
);
   reg level; // Pin level after polarity choice

   // Asserted level is high unless inverted
   always @* begin
      level = invert ? ~request : request;
   end

   // Push-pull always drives; open-drain only pulls low while level is high
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pin_o <= 1'b0;
         irq_pin_oe <= 1'b0;
      end else if (push_pull) begin
         irq_pin_o <= level;
         irq_pin_oe <= 1'b1;
      end else begin
         // Open drain can only pull low, so the asserted state must be low
         irq_pin_o <= 1'b0;
         irq_pin_oe <= level;
      end
   end
endmodule // nie_pin_drive

// File: rtl/nie_sync2.v
// Purpose: Two flip-flop synchroniser for one level
// Assumes: Input is asynchronous to ref_clk
// Notes: First stage is read only by the second
`timescale 1ns/100ps
module nie_sync2 (
   input wire ref_clk,
   input wire rst_n,
   input wire din,
   output reg dout
);
   reg meta_reg; // First stage, read only by the second stage

   // Two stage capture
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule // nie_sync2
